// ### verilog/pc_next_map.svh
// Constants for the program-counter next-address block
// Summary of operation
// - Without a taken branch, the counter advances one per fetched instruction byte.
// - A taken branch loads the destination instead of the sequential increment.
// - Relative target is displacement byte plus start address of the next instruction.
// - Displacement is signed two's complement, reaching -128 through +127.
// - Bit 7 of the displacement byte is its sign bit.
// - Upper bits are filled with copies of the sign before adding.
// - Relative targets serve the unconditional jump and every conditional branch.
`ifndef PC_NEXT_MAP_SVH
`define PC_NEXT_MAP_SVH
`define PC_RESET_VALUE      16'h0000
`define PC_WIDTH            16
`define DISP_SIGN_BIT       7
`define INSN_LEN_MAX        3'h4
`endif

// ### verilog/pc_next_pkg.sv
// Types for the program-counter next-address block
package pc_next_pkg;
   typedef enum logic [1:0] {
      BR_NONE,
      BR_RELATIVE,
      BR_ABSOLUTE
   } branch_kind_t;
endpackage

// ### verilog/rel_target_adder.sv
// Relative branch target adder: sign-extends a displacement byte and adds it
`include "pc_next_map.svh"
module rel_target_adder #(
   parameter int PC_W = `PC_WIDTH
) (
   input  wire logic [PC_W-1:0] next_insn_addr,
   input  wire logic [7:0]      branch_displacement_byte,
   output logic      [PC_W-1:0] target_addr
);
   logic [PC_W-1:0] disp_ext;

   // Sign bit copied into every upper bit
   assign disp_ext = {{(PC_W-8){branch_displacement_byte[`DISP_SIGN_BIT]}},
                      branch_displacement_byte};
   // Sum cut to the counter width, wrapping at the top of memory
   assign target_addr = PC_W'(next_insn_addr + disp_ext);
endmodule

// ### verilog/pc_next_relative_branch.sv
// Program-counter next-address logic with relative branch support
`include "pc_next_map.svh"
module pc_next_relative_branch #(
   parameter int PC_W = `PC_WIDTH
) (
   input  wire logic                       ref_clk,
   input  wire logic                       reset_n,
   input  wire logic                       fetch_valid,
   input  wire logic [2:0]                 insn_len,
   input  wire pc_next_pkg::branch_kind_t  branch_kind,
   input  wire logic                       branch_taken,
   input  wire logic [7:0]                 branch_displacement_byte,
   input  wire logic [PC_W-1:0]            absolute_target,
   output logic      [PC_W-1:0]            pc,
   output logic      [PC_W-1:0]            next_insn_addr
);
   import pc_next_pkg::*;

   logic [PC_W-1:0] pc_reg;
   logic [PC_W-1:0] pc_next;
   logic [PC_W-1:0] rel_target;
   logic [PC_W-1:0] seq_addr;
   logic            len_ok;

   // Lengths outside 1..4 cannot come from the decoder; they count as one byte
   function automatic logic len_valid(input logic [2:0] len);
      return (len != 3'h0) && (len <= `INSN_LEN_MAX);
   endfunction

   // Step of a sequential fetch, so a bad length never stalls the counter
   function automatic logic [PC_W-1:0] fetch_step(input logic [2:0] len);
      logic [PC_W-1:0] step_bytes;
      step_bytes = {{(PC_W-1){1'h0}}, 1'h1};
      if (len_valid(len)) begin
         step_bytes = {{(PC_W-3){1'h0}}, len};
      end
      return step_bytes;
   endfunction

   assign len_ok   = len_valid(insn_len);
   assign seq_addr = PC_W'(pc_reg + fetch_step(insn_len));

   rel_target_adder #(
      .PC_W (PC_W)
   ) rel_target_adder_inst (
      .next_insn_addr           (seq_addr),
      .branch_displacement_byte (branch_displacement_byte),
      .target_addr              (rel_target)
   );

   always_comb begin
      pc_next = pc_reg;
      if (fetch_valid) begin
         pc_next = seq_addr;
         if (branch_taken) begin
            unique case (branch_kind)
               // Unconditional jump and conditionals share one adder
               BR_RELATIVE: pc_next = rel_target;
               BR_ABSOLUTE: pc_next = absolute_target;
               BR_NONE:     pc_next = seq_addr;
               // Code 3 never comes from the decoder; fall back to sequential flow
               default:     pc_next = seq_addr;
            endcase
         end
      end
   end

   // Asynchronous clear, so fetch starts at the reset address even without a clock
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         pc_reg <= `PC_RESET_VALUE;
      end else begin
         pc_reg <= pc_next;
      end
   end

   assign pc             = pc_reg;
   assign next_insn_addr = seq_addr;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   a_seq_advance: assert property (
      fetch_valid && !branch_taken && len_ok
      |=> pc == PC_W'($past(pc) + {{(PC_W-3){1'b0}}, $past(insn_len)}))
      else $error("sequential advance wrong");

   a_rel_target: assert property (
      fetch_valid && branch_taken && branch_kind == BR_RELATIVE
      |=> pc == PC_W'($past(next_insn_addr)
                      + {{(PC_W-8){$past(branch_displacement_byte[7])}},
                         $past(branch_displacement_byte)}))
      else $error("relative target wrong");

   a_neg_disp: assert property (
      fetch_valid && branch_taken && branch_kind == BR_RELATIVE
      && branch_displacement_byte == 8'h80
      |=> pc == PC_W'($past(next_insn_addr) - 16'h0080))
      else $error("minus 128 reach wrong");

   a_pos_disp: assert property (
      fetch_valid && branch_taken && branch_kind == BR_RELATIVE
      && branch_displacement_byte == 8'h7F
      |=> pc == PC_W'($past(next_insn_addr) + 16'h007F))
      else $error("plus 127 reach wrong");

   a_sign_bit: assert property (
      branch_displacement_byte[7] |-> rel_target != PC_W'(seq_addr + 16'h0100)
      && (rel_target - seq_addr) >= PC_W'(16'hFF80))
      else $error("sign bit ignored");

   a_sign_fill: assert property (
      !branch_displacement_byte[7] |-> PC_W'(rel_target - seq_addr) <= 16'h007F)
      else $error("zero fill wrong");

   a_abs_load: assert property (
      fetch_valid && branch_taken && branch_kind == BR_ABSOLUTE
      |=> pc == $past(absolute_target))
      else $error("absolute load wrong");

   a_wrap_top: assert property (
      fetch_valid && branch_taken && branch_kind == BR_RELATIVE
      && next_insn_addr == 16'hFFFF && branch_displacement_byte == 8'h01
      |=> pc == 16'h0000)
      else $error("carry not dropped");

   a_hold_idle: assert property (
      !fetch_valid |=> $stable(pc))
      else $error("pc moved without fetch");

   a_len_invalid: assert property (
      fetch_valid && !branch_taken && !len_ok
      |=> pc == PC_W'($past(pc) + 16'h0001))
      else $error("invalid length step wrong");

   a_step_bound: assert property (
      fetch_valid && !branch_taken
      |=> PC_W'(pc - $past(pc)) >= 16'h0001 && PC_W'(pc - $past(pc)) <= 16'h0004)
      else $error("sequential step out of range");

   // Back-to-back requests, as the fetch stage may issue one every cycle
   a_two_steps: assert property (
      (fetch_valid && !branch_taken && len_ok)
      ##1 (fetch_valid && !branch_taken && len_ok)
      |=> pc == PC_W'($past(pc, 2)
                      + {{(PC_W-3){1'h0}}, $past(insn_len, 2)}
                      + {{(PC_W-3){1'h0}}, $past(insn_len)}))
      else $error("back to back advance wrong");

   a_idle_branch: assert property (
      !fetch_valid && branch_taken |=> pc == $past(pc))
      else $error("branch taken without fetch");

   a_taken_none: assert property (
      fetch_valid && branch_taken && branch_kind == BR_NONE
      |=> pc == $past(next_insn_addr))
      else $error("branch without kind moved pc");

   a_abs_over_seq: assert property (
      fetch_valid && branch_taken && branch_kind == BR_ABSOLUTE
      && absolute_target != next_insn_addr
      |=> pc != $past(next_insn_addr))
      else $error("increment not replaced");

   a_next_addr: assert property (
      len_ok |-> next_insn_addr == PC_W'(pc + {{(PC_W-3){1'h0}}, insn_len}))
      else $error("following address wrong");

   a_next_invalid: assert property (
      !len_ok |-> next_insn_addr == PC_W'(pc + 16'h0001))
      else $error("following address for bad length wrong");

   a_disp_zero: assert property (
      fetch_valid && branch_taken && branch_kind == BR_RELATIVE
      && branch_displacement_byte == 8'h00
      |=> pc == $past(next_insn_addr))
      else $error("zero displacement wrong");

   a_cond_untaken: assert property (
      fetch_valid && !branch_taken && branch_kind == BR_RELATIVE
      |=> pc == $past(next_insn_addr))
      else $error("untaken conditional moved pc");

   a_fwd_one: assert property (
      fetch_valid && branch_taken && branch_kind == BR_RELATIVE
      && branch_displacement_byte == 8'h01
      |=> pc == PC_W'($past(next_insn_addr) + 16'h0001))
      else $error("plus one reach wrong");

   a_back_one: assert property (
      fetch_valid && branch_taken && branch_kind == BR_RELATIVE
      && branch_displacement_byte == 8'hFF
      |=> pc == PC_W'($past(next_insn_addr) - 16'h0001))
      else $error("minus one reach wrong");

   a_back_reach: assert property (
      fetch_valid && branch_taken && branch_kind == BR_RELATIVE
      && branch_displacement_byte[7]
      |=> PC_W'(pc - $past(next_insn_addr)) >= 16'hFF80)
      else $error("backward reach wrong");

   a_fwd_reach: assert property (
      fetch_valid && branch_taken && branch_kind == BR_RELATIVE
      && !branch_displacement_byte[7]
      |=> PC_W'(pc - $past(next_insn_addr)) <= 16'h007F)
      else $error("forward reach wrong");

   a_wrap_bottom: assert property (
      fetch_valid && branch_taken && branch_kind == BR_RELATIVE
      && next_insn_addr == 16'h0000 && branch_displacement_byte == 8'hFF
      |=> pc == 16'hFFFF)
      else $error("borrow not dropped");

   c_rel_back: cover property (fetch_valid && branch_taken
      && branch_kind == BR_RELATIVE && branch_displacement_byte[7]);
   c_rel_fwd: cover property (fetch_valid && branch_taken
      && branch_kind == BR_RELATIVE && !branch_displacement_byte[7]);
   c_abs: cover property (fetch_valid && branch_taken && branch_kind == BR_ABSOLUTE);
   c_seq3: cover property (fetch_valid && !branch_taken && insn_len == 3'h3);
   c_wrap: cover property (fetch_valid && branch_taken
      && branch_kind == BR_RELATIVE && next_insn_addr == 16'hFFFF);
endmodule

// ### tb/pc_next_relative_branch_tb_top.sv
// Self-checking bench for the program-counter next-address block
module pc_next_relative_branch_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import pc_next_pkg::*;
   logic         ref_clk = 1'b0;
   logic         reset_n = 1'b0;
   logic         fv = 1'b0;
   logic         tk = 1'b0;
   logic [2:0]   len = 3'h1;
   branch_kind_t kd = BR_NONE;
   logic [7:0]   dp = 8'h00;
   logic [15:0]  at = 16'h0000;
   logic [15:0]  pc;
   logic [15:0]  nia;
   logic [15:0]  exp_pc = 16'h0000;
   int           n_mismatch = 0;
   int           checked = 0;
   pc_next_relative_branch pc_next_relative_branch_inst (
      .ref_clk(ref_clk), .reset_n(reset_n), .fetch_valid(fv), .insn_len(len),
      .branch_kind(kd), .branch_taken(tk), .branch_displacement_byte(dp),
      .absolute_target(at), .pc(pc), .next_insn_addr(nia));
   initial forever #2.5 ref_clk = ~ref_clk;
   task automatic test_done();
      if (n_mismatch == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   // Absolute target differs from the expected one except in absolute steps, so misrouting shows
   task automatic step(input logic v, input logic [2:0] l, input branch_kind_t k,
                       input logic t, input logic [7:0] d, input logic [15:0] e);
      @(negedge ref_clk);
      fv = v;
      len = l;
      kd = k;
      tk = t;
      dp = d;
      at = (k == BR_ABSOLUTE) ? e : ~e;
      #1 cmp(nia, exp_pc + ((l == 3'h0 || l > 3'h4) ? 16'h1 : {13'h0, l}));
      @(posedge ref_clk);
      #1 cmp(pc, e);
      exp_pc = e;
   endtask
   task automatic seq_flow();
      step(1, 3'h2, BR_ABSOLUTE, 1, 8'h00, 16'h1000);
      step(1, 3'h3, BR_NONE, 0, 8'h55, 16'h1003);
      step(1, 3'h1, BR_RELATIVE, 0, 8'h40, 16'h1004);
      step(1, 3'h4, BR_NONE, 0, 8'h00, 16'h1008);
      step(1, 3'h0, BR_NONE, 0, 8'h00, 16'h1009);
      step(0, 3'h2, BR_RELATIVE, 1, 8'h10, 16'h1009);
      step(1, 3'h2, BR_NONE, 1, 8'hF0, 16'h100B);
   endtask
   task automatic rel_signed();
      step(1, 3'h2, BR_RELATIVE, 1, 8'hFE, 16'h100B);
      step(1, 3'h2, BR_RELATIVE, 1, 8'h80, 16'h0F8D);
      step(1, 3'h3, BR_RELATIVE, 1, 8'h7F, 16'h100F);
      step(1, 3'h2, BR_RELATIVE, 0, 8'h80, 16'h1011);
      step(1, 3'h2, BR_RELATIVE, 1, 8'h00, 16'h1013);
   endtask
   task automatic rel_wrap();
      step(1, 3'h3, BR_ABSOLUTE, 1, 8'h00, 16'hFFFE);
      step(1, 3'h2, BR_RELATIVE, 1, 8'h05, 16'h0005);
      step(1, 3'h2, BR_RELATIVE, 1, 8'hF0, 16'hFFF7);
      step(1, 3'h5, BR_NONE, 0, 8'h00, 16'hFFF8);
      step(1, 3'h7, BR_RELATIVE, 1, 8'h06, 16'hFFFF);
      step(1, 3'h1, BR_RELATIVE, 1, 8'hFF, 16'hFFFF);
      step(1, 3'h1, BR_RELATIVE, 1, 8'hFE, 16'hFFFE);
      step(1, 3'h1, BR_RELATIVE, 1, 8'h01, 16'h0000);
   endtask
   initial begin
      repeat (8) @(posedge ref_clk);
      @(negedge ref_clk);
      reset_n = 1'b1;
      cmp(pc, 16'h0000);
      seq_flow();
      rel_signed();
      rel_wrap();
      test_done();
   end
   initial begin
      repeat (400) @(posedge ref_clk);
      n_mismatch++;
      test_done();
   end
endmodule
